/* design/addr_branch_regs.svh */
// register map, field positions, reset values and bus answers of the
// addressing and branch control block; definitions only
`ifndef ADDR_BRANCH_REGS_SVH
`define ADDR_BRANCH_REGS_SVH

// byte offsets on the register bus
`define OFF_CTRL 8'h00
`define OFF_INSN 8'h04
`define OFF_PC 8'h08
`define OFF_GBR 8'h0C
`define OFF_STATUS_WORD 8'h10
`define OFF_SAVED_STATUS 8'h14
`define OFF_SAVED_PC 8'h18
`define OFF_MMU_CTRL 8'h1C
`define OFF_PAGE_ENTRY_HIGH 8'h20
`define OFF_LOAD_DATA 8'h24
`define OFF_EA 8'h28
`define OFF_TARGET 8'h2C
`define OFF_RESULT 8'h30
`define OFF_CORE_STATE 8'h34
`define OFF_GREG_BASE 8'h40

// control register bits
`define CTRL_GO 0
`define CTRL_CLR_ILLEGAL 1
`define CTRL_PAIR 2

// status word bits
`define SR_T 0
`define SR_S 1
`define SR_Q 8
`define SR_M 9
`define SR_FD 15
`define SR_BL 28
`define SR_RB 29
`define SR_MD 30

// mmu control bits
`define MMU_VIRTUAL_MODE 0
`define MMU_SINGLE_SPACE 8

// reset values
`define PC_RST 32'hA000_0000
`define SR_RST 32'h7000_0000

// pc-relative base offset and longword alignment mask
`define PC_AHEAD 32'h0000_0004
`define PC_STEP 32'h0000_0002
`define LONG_MASK 32'hFFFF_FFFC

// bus answers
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

/* design/addr_branch_pkg.sv */
// types shared by the addressing and branch control block
// assumes addr_branch_regs.svh supplies the numeric constants
package addr_branch_pkg;

  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_RD = 6'h02,
    ST_EX = 6'h04,
    ST_WB = 6'h08,
    ST_AXR1 = 6'h10,
    ST_AXR2 = 6'h20
  } state_t;

  typedef enum logic [1:0] {
    SZ_B = 2'h0,
    SZ_W = 2'h1,
    SZ_L = 2'h2,
    SZ_Q = 2'h3
  } size_t;

  typedef struct packed {
    state_t state;
    logic [15:0] insn;
    logic [31:0] pc;
    logic [31:0] global_base_reg;
    logic [31:0] sr;
    logic [31:0] ssr;
    logic [31:0] spc;
    logic [31:0] mmu;
    logic [31:0] page_entry_high_reg;
    logic [31:0] load;
    logic [31:0] ea;
    logic [31:0] tgt;
    logic [31:0] result;
    logic slot;
    logic pend_taken;
    logic [31:0] pend_tgt;
    logic rte_slot;
    logic old_md;
    logic illegal;
    logic pair;
    logic [3:0] ra;
    logic [3:0] rb;
    logic we;
    logic [3:0] wa;
    logic [31:0] wd;
    logic dst_pend;
    logic [3:0] dst_idx;
    logic [31:0] dst_val;
    logic aw_h;
    logic [7:0] awaddr;
    logic w_h;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic ar_h;
    logic [7:0] araddr;
    logic awready;
    logic wready;
    logic arready;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic mem_rd;
    logic mem_wr;
    size_t mem_size;
    logic fetch_priv;
    logic data_priv;
    logic xlate;
    logic sid_valid;
    logic [7:0] space_id;
  } core_t;

endpackage

/* design/greg_file.sv */
// sixteen general registers, three registered read ports, one write port
// assumes the caller waits one cycle after presenting a read address
`timescale 1ns/1ns
module greg_file (
  // clock
  input wire logic aclk,
  // read addresses
  input wire logic [3:0] ra,
  input wire logic [3:0] rb,
  // write port
  input wire logic we,
  input wire logic [3:0] wa,
  input wire logic [31:0] wd,
  // registered read data
  output logic [31:0] rda,
  output logic [31:0] rdb,
  output logic [31:0] rd0
);

  logic [31:0] mem [0:15];

  // storage has no reset; software loads it before use
  always_ff @(posedge aclk)
  begin
    if (we)
    begin
      mem[wa] <= wd;
    end
    rda <= mem[ra];
    rdb <= mem[rb];
    rd0 <= mem[0];
  end

endmodule

/* design/ext_unit.sv */
// extension and scaling of instruction fields and of loaded data
// purely combinational; the caller supplies the operand size
`timescale 1ns/1ns
module ext_unit
  import addr_branch_pkg::*;
(
  // instruction and operand size
  input wire logic [15:0] op,
  input wire size_t sz,
  input wire logic [31:0] raw,
  // scaled displacements
  output logic [31:0] d4,
  output logic [31:0] d8,
  output logic [31:0] br8,
  output logic [31:0] br12,
  // immediates and loaded data
  output logic [31:0] imms,
  output logic [31:0] immz,
  output logic [31:0] trapv,
  output logic [31:0] ldx
);

  assign d4 = {28'h0, op[3:0]} << sz;
  assign d8 = {24'h0, op[7:0]} << sz;
  assign br8 = {{23{op[7]}}, op[7:0], 1'b0};
  assign br12 = {{19{op[11]}}, op[11:0], 1'b0};
  assign imms = {{24{op[7]}}, op[7:0]};
  assign immz = {24'h0, op[7:0]};
  assign trapv = {22'h0, op[7:0], 2'h0};

  always_comb
  begin
    case (sz)
      SZ_B: ldx = {{24{raw[7]}}, raw[7:0]};
      SZ_W: ldx = {{16{raw[15]}}, raw[15:0]};
      default: ldx = raw;
    endcase
  end

endmodule

/* design/addr_branch_ctl.sv */
// addressing and branch control: executes one 16-bit instruction per go
// command, forms effective addresses and branch targets, keeps pc, status
// and delay-slot state; registers reached over AXI4-Lite.
// assumes memory data for loads is placed in the load data register first.
//
// Decided for this implementation: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/1ns
`include "addr_branch_regs.svh"
module addr_branch_ctl
  import addr_branch_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // write address and data
  input wire logic awvalid,
  output logic awready,
  input wire logic [7:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  // write response
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // read address and data
  input wire logic arvalid,
  output logic arready,
  input wire logic [7:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // memory side
  output logic [31:0] mem_addr,
  output logic mem_rd,
  output logic mem_wr,
  output logic [1:0] mem_size,
  output logic [31:0] fetch_addr,
  output logic fetch_priv,
  output logic data_priv,
  output logic xlate_en,
  output logic sid_valid,
  output logic [7:0] space_id
);

  core_t s;
  core_t n;
  size_t sz;
  logic [31:0] rda;
  logic [31:0] rdb;
  logic [31:0] rd0;
  logic [31:0] d4;
  logic [31:0] d8;
  logic [31:0] br8;
  logic [31:0] br12;
  logic [31:0] imms;
  logic [31:0] immz;
  logic [31:0] trapv;
  logic [31:0] ldx;
  logic [31:0] step;
  logic [31:0] pc4;
  logic do_wr;

  // operand size from the opcode and the pair bit, kept apart from the main decode
  function automatic size_t size_of(input logic [15:0] op, input logic pair);
    casez (op)
      16'b1001_????_????_????: size_of = SZ_W;
      16'b1100_0111_????_????: size_of = SZ_L;
      16'b0110_????_????_0???: size_of = size_t'(op[1:0]);
      16'b0010_????_????_0???: size_of = size_t'(op[1:0]);
      16'b0000_????_????_11??: size_of = size_t'(op[1:0]);
      16'b1000_010?_????_????: size_of = size_t'(op[9:8]);
      16'b1100_0???_????_????: size_of = size_t'(op[9:8]);
      16'b1100_11??_????_????: size_of = SZ_B;
      16'b1111_????_????_10?1: size_of = pair ? SZ_Q : SZ_L;
      default: size_of = SZ_L;
    endcase
  endfunction

  // byte lanes for internal registers
  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] d,
                                        input logic [3:0] st);
    merge = o;
    for (int i = 0; i < 4; i++)
    begin
      if (st[i])
      begin
        merge[i*8 +: 8] = d[i*8 +: 8];
      end
    end
  endfunction

  assign sz = size_of(s.insn, s.pair);
  // step and pc base wrap at 32 bits
  assign step = 32'h1 << sz;
  assign pc4 = s.pc + `PC_AHEAD;
  assign do_wr = s.aw_h && s.w_h && !s.bvalid && (s.state == ST_IDLE);

  greg_file u_greg (
    .aclk(aclk),
    .ra(s.ra),
    .rb(s.rb),
    .we(s.we),
    .wa(s.wa),
    .wd(s.wd),
    .rda(rda),
    .rdb(rdb),
    .rd0(rd0)
  );

  ext_unit u_ext (
    .op(s.insn),
    .sz(sz),
    .raw(s.load),
    .d4(d4),
    .d8(d8),
    .br8(br8),
    .br12(br12),
    .imms(imms),
    .immz(immz),
    .trapv(trapv),
    .ldx(ldx)
  );

  // next state of the whole block
  always_comb
  begin
    logic [31:0] ea;
    logic [31:0] tg;
    logic acc;
    logic st;
    logic upd;
    logic [3:0] ui;
    logic [31:0] uv;
    logic dw;
    logic [3:0] di;
    logic [31:0] dv;
    logic dly;
    logic nd;
    logic tk;
    logic bad;
    logic exception_return_op;
    logic [31:0] sr;
    logic [31:0] rv;
    ea = 32'h0;
    tg = 32'h0;
    acc = 1'b0;
    st = 1'b0;
    upd = 1'b0;
    ui = s.insn[11:8];
    uv = 32'h0;
    dw = 1'b0;
    di = s.insn[11:8];
    dv = 32'h0;
    dly = 1'b0;
    nd = 1'b0;
    tk = 1'b0;
    bad = 1'b0;
    exception_return_op = 1'b0;
    sr = s.sr;
    rv = 32'h0;
    n = s;
    n.we = 1'b0;
    n.mem_rd = 1'b0;
    n.mem_wr = 1'b0;

    // decode and address generation, used only in the execute state
    casez (s.insn)
      16'b1110_????_????_????: begin dw = 1'b1; dv = imms; end
      16'b0111_????_????_????: begin dw = 1'b1; dv = rda + imms; end
      16'b1000_1000_????_????: sr[`SR_T] = (rd0 == imms);
      16'b0011_????_????_0000: sr[`SR_T] = (rda == rdb);
      16'b1100_10??_????_????:
      begin
        di = 4'h0;
        dw = (s.insn[9:8] != 2'h0);
        case (s.insn[9:8])
          2'h0: sr[`SR_T] = ((rd0 & immz) == 32'h0);
          2'h1: dv = rd0 & immz;
          2'h2: dv = rd0 ^ immz;
          default: dv = rd0 | immz;
        endcase
      end
      16'b1001_????_????_????: begin ea = pc4 + d8; acc = 1'b1; dw = 1'b1; bad = 1'b1; end
      16'b1101_????_????_????:
      begin
        ea = (s.pc & `LONG_MASK) + `PC_AHEAD + d8;
        acc = 1'b1;
        dw = 1'b1;
        bad = 1'b1;
      end
      16'b1100_0111_????_????:
      begin
        di = 4'h0;
        dw = 1'b1;
        dv = (s.pc & `LONG_MASK) + `PC_AHEAD + d8;
        bad = 1'b1;
      end
      16'b1100_0011_????_????: begin rv = trapv; bad = 1'b1; end
      16'b0110_????_????_0011: begin dw = 1'b1; dv = rdb; end
      16'b0110_????_????_01??:
      begin
        ea = rdb;
        acc = 1'b1;
        dw = 1'b1;
        upd = 1'b1;
        ui = s.insn[7:4];
        uv = rdb + step;
      end
      16'b0110_????_????_00??: begin ea = rdb; acc = 1'b1; dw = 1'b1; end
      16'b1111_????_????_1001:
      begin
        ea = rdb;
        acc = 1'b1;
        upd = 1'b1;
        ui = s.insn[7:4];
        uv = rdb + step;
      end
      16'b0010_????_????_01??: begin ea = rda - step; st = 1'b1; upd = 1'b1; uv = ea; end
      16'b1111_????_????_1011: begin ea = rda - step; st = 1'b1; upd = 1'b1; uv = ea; end
      16'b0010_????_????_00??: begin ea = rda; st = 1'b1; end
      16'b1000_010?_????_????: begin ea = rdb + d4; acc = 1'b1; dw = 1'b1; di = 4'h0; end
      16'b0101_????_????_????: begin ea = rdb + d4; acc = 1'b1; dw = 1'b1; end
      16'b0001_????_????_????: begin ea = rda + d4; st = 1'b1; end
      16'b0000_????_????_11??: begin ea = rd0 + rdb; acc = 1'b1; dw = 1'b1; end
      16'b0000_????_????_01??: begin ea = rd0 + rda; st = 1'b1; end
      16'b1100_01??_????_????: begin ea = s.global_base_reg + d8; acc = 1'b1; dw = 1'b1; di = 4'h0; end
      16'b1100_00??_????_????: begin ea = s.global_base_reg + d8; st = 1'b1; end
      16'b1100_11??_????_????: begin ea = s.global_base_reg + rd0; acc = 1'b1; end
      16'b101?_????_????_????: begin tg = pc4 + br12; dly = 1'b1; tk = 1'b1; bad = 1'b1; end
      // conditional; only the /s forms are delayed
      16'b1000_1??1_????_????:
      begin
        tg = pc4 + br8;
        tk = s.sr[`SR_T] ^ s.insn[9];
        dly = s.insn[10];
        nd = !s.insn[10];
        bad = 1'b1;
      end
      16'b0000_????_0010_0011: begin tg = pc4 + rda; dly = 1'b1; tk = 1'b1; bad = 1'b1; end
      16'b0000_0000_0010_1011:
      begin
        tg = s.spc;
        sr = s.ssr;
        dly = 1'b1;
        tk = 1'b1;
        exception_return_op = 1'b1;
        bad = 1'b1;
      end
      // status store sees the value already updated
      16'b0000_????_0000_0010: begin dw = 1'b1; dv = s.sr; end
      default: ;
    endcase
    // loads take the extended memory word
    if (acc && dw)
    begin
      dv = ldx;
    end

    // register bus write side
    if (s.awready && awvalid)
    begin
      n.aw_h = 1'b1;
      n.awaddr = awaddr;
    end
    if (s.wready && wvalid)
    begin
      n.w_h = 1'b1;
      n.wdata = wdata;
      n.wstrb = wstrb;
    end
    if (do_wr)
    begin
      n.bvalid = 1'b1;
      n.bresp = `RESP_OKAY;
      case (s.awaddr)
        `OFF_CTRL:
        begin
          n.pair = s.wstrb[0] ? s.wdata[`CTRL_PAIR] : s.pair;
          if (s.wstrb[0] && s.wdata[`CTRL_CLR_ILLEGAL])
          begin
            n.illegal = 1'b0;
          end
          if (s.wstrb[0] && s.wdata[`CTRL_GO])
          begin
            n.state = ST_RD;
            n.ra = s.insn[11:8];
            n.rb = s.insn[7:4];
          end
        end
        `OFF_INSN: n.insn = 16'(merge({16'h0, s.insn}, s.wdata, s.wstrb));
        `OFF_PC: n.pc = merge(s.pc, s.wdata, s.wstrb);
        `OFF_GBR: n.global_base_reg = merge(s.global_base_reg, s.wdata, s.wstrb);
        `OFF_STATUS_WORD: n.sr = merge(s.sr, s.wdata, s.wstrb);
        `OFF_SAVED_STATUS: n.ssr = merge(s.ssr, s.wdata, s.wstrb);
        `OFF_SAVED_PC: n.spc = merge(s.spc, s.wdata, s.wstrb);
        `OFF_MMU_CTRL: n.mmu = merge(s.mmu, s.wdata, s.wstrb);
        `OFF_PAGE_ENTRY_HIGH: n.page_entry_high_reg = merge(s.page_entry_high_reg, s.wdata, s.wstrb);
        `OFF_LOAD_DATA: n.load = merge(s.load, s.wdata, s.wstrb);
        default:
        begin
          // general registers take the whole word; the rest is unmapped
          if (s.awaddr[7:6] == 2'h1 && s.awaddr[1:0] == 2'h0)
          begin
            n.we = 1'b1;
            n.wa = s.awaddr[5:2];
            n.wd = s.wdata;
          end
          else
          begin
            n.bresp = `RESP_SLVERR;
          end
        end
      endcase
    end
    if (s.bvalid && bready)
    begin
      n.bvalid = 1'b0;
      n.aw_h = 1'b0;
      n.w_h = 1'b0;
    end

    // register bus read side; a write in the same cycle goes first
    if (s.arready && arvalid)
    begin
      n.ar_h = 1'b1;
      n.araddr = araddr;
    end
    case (s.araddr)
      `OFF_CTRL: rv = {29'h0, s.pair, 2'h0};
      `OFF_INSN: rv = {16'h0, s.insn};
      `OFF_PC: rv = s.pc;
      `OFF_GBR: rv = s.global_base_reg;
      `OFF_STATUS_WORD: rv = s.sr;
      `OFF_SAVED_STATUS: rv = s.ssr;
      `OFF_SAVED_PC: rv = s.spc;
      `OFF_MMU_CTRL: rv = s.mmu;
      `OFF_PAGE_ENTRY_HIGH: rv = s.page_entry_high_reg;
      `OFF_LOAD_DATA: rv = s.load;
      `OFF_EA: rv = s.ea;
      `OFF_TARGET: rv = s.tgt;
      `OFF_RESULT: rv = s.result;
      `OFF_CORE_STATE: rv = {26'h0, s.illegal, s.pend_taken, s.rte_slot, s.slot,
                             s.state != ST_IDLE, 1'b0};
      default: rv = 32'h0;
    endcase
    if (s.ar_h && !s.rvalid && s.state == ST_IDLE && !do_wr)
    begin
      if (s.araddr[7:6] == 2'h1 && s.araddr[1:0] == 2'h0)
      begin
        n.state = ST_AXR1;
        n.ra = s.araddr[5:2];
      end
      else
      begin
        n.rvalid = 1'b1;
        n.rdata = rv;
        n.rresp = (s.araddr > `OFF_CORE_STATE || s.araddr[1:0] != 2'h0) ?
                  `RESP_SLVERR : `RESP_OKAY;
      end
    end
    if (s.rvalid && rready)
    begin
      n.rvalid = 1'b0;
      n.ar_h = 1'b0;
    end

    // sequencing
    case (s.state)
      ST_IDLE: ;
      ST_RD: n.state = ST_EX;
      ST_AXR1: n.state = ST_AXR2;
      ST_AXR2:
      begin
        n.state = ST_IDLE;
        n.rvalid = 1'b1;
        n.rdata = rda;
        n.rresp = `RESP_OKAY;
      end
      ST_EX:
      begin
        n.state = ST_IDLE;
        // disallowed instruction in a slot does nothing else
        if (s.slot && bad)
        begin
          n.illegal = 1'b1;
          n.slot = 1'b0;
          n.rte_slot = 1'b0;
        end
        else
        begin
          // status bits change at once, slot sees them
          n.sr = sr;
          n.ea = ea;
          n.tgt = tg;
          n.result = (acc || dw) ? dv : rv;
          // data access goes out with translation state
          n.mem_rd = acc;
          n.mem_wr = st;
          n.mem_size = sz;
          n.we = upd;
          n.wa = ui;
          n.wd = uv;
          n.dst_pend = dw;
          n.dst_idx = di;
          n.dst_val = dv;
          if (upd && dw)
          begin
            n.state = ST_WB;
          end
          else if (dw)
          begin
            n.we = 1'b1;
            n.wa = di;
            n.wd = dv;
          end
          // pc moves only after the instruction used it
          if (s.slot)
          begin
            n.pc = s.pend_taken ? s.pend_tgt : s.pc + `PC_STEP;
            n.slot = 1'b0;
            n.rte_slot = 1'b0;
          end
          else if (dly)
          begin
            // slot follows even when not taken
            n.pc = s.pc + `PC_STEP;
            n.slot = 1'b1;
            n.pend_taken = tk;
            n.pend_tgt = tg;
            n.rte_slot = exception_return_op;
            n.old_md = s.sr[`SR_MD];
          end
          else
          begin
            n.pc = (nd && tk) ? tg : s.pc + `PC_STEP;
          end
        end
      end
      ST_WB:
      begin
        // loaded value wins when both writes name one register
        n.state = ST_IDLE;
        n.we = 1'b1;
        n.wa = s.dst_idx;
        n.wd = s.dst_val;
      end
      default: n.state = ST_IDLE;
    endcase

    // a set in the same cycle beats the software clear
    if (s.state == ST_EX && s.slot && bad)
    begin
      n.illegal = 1'b1;
    end

    // each ready only while its own channel holds nothing
    n.awready = !n.aw_h;
    n.wready = !n.w_h;
    n.arready = !n.ar_h;
    // fetch mode lags in the return slot, data mode does not
    n.fetch_priv = n.rte_slot ? n.old_md : n.sr[`SR_MD];
    n.data_priv = n.sr[`SR_MD];
    n.xlate = n.mmu[`MMU_VIRTUAL_MODE];
    n.sid_valid = n.mmu[`MMU_VIRTUAL_MODE] && !n.mmu[`MMU_SINGLE_SPACE];
    n.space_id = n.page_entry_high_reg[7:0];
  end

  // one register for all state
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s <= '0;
      s.state <= ST_IDLE;
      s.pc <= `PC_RST;
      s.sr <= `SR_RST;
      s.mem_size <= SZ_B;
      s.fetch_priv <= 1'b1;
      s.data_priv <= 1'b1;
    end
    else
    begin
      s <= n;
    end
  end

  // outputs straight from the state register
  assign awready = s.awready;
  assign wready = s.wready;
  assign bvalid = s.bvalid;
  assign bresp = s.bresp;
  assign arready = s.arready;
  assign rvalid = s.rvalid;
  assign rdata = s.rdata;
  assign rresp = s.rresp;
  assign mem_addr = s.ea;
  assign mem_rd = s.mem_rd;
  assign mem_wr = s.mem_wr;
  assign mem_size = s.mem_size;
  assign fetch_addr = s.pc;
  assign fetch_priv = s.fetch_priv;
  assign data_priv = s.data_priv;
  assign xlate_en = s.xlate;
  assign sid_valid = s.sid_valid;
  assign space_id = s.space_id;

endmodule

/* tb/addr_branch_chk.sv */
// bus handshake and memory-side checks for the addressing block
// sees only top ports; bound to the design after the module
`timescale 1ns/1ns
module addr_branch_chk (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // bus handshakes
  input wire logic awvalid,
  input wire logic awready,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic [1:0] rresp,
  input wire logic [31:0] rdata,
  // memory side
  input wire logic mem_rd,
  input wire logic mem_wr,
  input wire logic xlate_en,
  input wire logic sid_valid
);
  // all checks share one domain
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  b_hold_a: assert property (bvalid && !bready |=> bvalid) else $error("bvalid dropped");
  b_done_a: assert property (bvalid && bready |=> !bvalid) else $error("bvalid stuck");
  r_hold_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data moved");
  aw_block_a: assert property (awvalid && awready |=> !awready) else $error("aw not blocked");
  ar_answer_a: assert property (arvalid && arready |-> ##[1:40] rvalid)
    else $error("read not answered");
  err_zero_a: assert property (rvalid && rresp == 2'h2 |-> rdata == 32'h0)
    else $error("error read not zero");
  mem_pulse_a: assert property (mem_rd |=> !mem_rd) else $error("load pulse too long");
  mem_excl_a: assert property (!(mem_rd && mem_wr)) else $error("load and store");
  sid_gate_a: assert property (sid_valid |-> xlate_en) else $error("id without xlate");
endmodule
bind addr_branch_ctl addr_branch_chk chk_i (.aclk, .aresetn, .awvalid, .awready, .bvalid,
  .bready, .arvalid, .arready, .rvalid, .rready, .rresp, .rdata, .mem_rd, .mem_wr,
  .xlate_en, .sid_valid);

/* tb/mem_side_model.sv */
// memory system stand-in: records each data access of the block
// assumes mem_rd and mem_wr are one-clock pulses
`timescale 1ns/1ns
module mem_side_model (
  // access from the block
  input wire logic aclk,
  input wire logic mem_rd,
  input wire logic mem_wr,
  input wire logic [31:0] mem_addr,
  input wire logic [1:0] mem_size,
  // recorded access
  output logic [31:0] last_addr,
  output logic [1:0] last_size
);
  // capture on each pulse; address is kept as given, no translation here
  always @(posedge aclk)
    if (mem_rd || mem_wr)
    begin
      last_addr <= mem_addr;
      last_size <= mem_size;
    end
endmodule

/* tb/addr_branch_ctl_test.sv */
// testbench: drives the register bus, runs instructions, checks results
// assumes the design answers every bus request within the watchdog span
`timescale 1ns/1ns
module addr_branch_ctl_test;
  logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [7:0] awaddr = 0, araddr = 0, space_id;
  logic [31:0] wdata = 0, rdata, mem_addr, fetch_addr, last_addr, d;
  logic [3:0] wstrb = 4'hF;
  logic awready, wready, bvalid, arready, rvalid, mem_rd, mem_wr;
  logic fetch_priv, data_priv, xlate_en, sid_valid;
  logic [1:0] bresp, rresp, mem_size, last_size, r;
  int err_count = 0, samples_checked = 0;
  addr_branch_ctl dut (.aclk, .aresetn, .awvalid, .awready, .awaddr, .wvalid, .wready,
    .wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .rvalid, .rready,
    .rdata, .rresp, .mem_addr, .mem_rd, .mem_wr, .mem_size, .fetch_addr, .fetch_priv,
    .data_priv, .xlate_en, .sid_valid, .space_id);
  mem_side_model mem (.aclk, .mem_rd, .mem_wr, .mem_addr, .mem_size, .last_addr, .last_size);
  // 20 MHz clock
  initial forever #25 aclk = ~aclk;
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e)
    begin
      err_count++;
      $display("[ERR] %0t seen %h exp %h", $time, s, e);
    end
  endtask
  // readies are registered, so the value at the falling edge holds at the next rise
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic pa, pw, t;
    pa = 1;
    pw = 1;
    @(posedge aclk);
    {awaddr, wdata, awvalid, wvalid, bready} <= {a, v, 3'b111};
    while (pa || pw)
    begin
      @(negedge aclk);
      t = pa && !awready;
      pw = pw && !wready;
      pa = t;
      @(posedge aclk);
      if (!pa) awvalid <= 1'b0;
      if (!pw) wvalid <= 1'b0;
    end
    do begin @(negedge aclk); {t, r} = {bvalid, bresp}; @(posedge aclk); end while (!t);
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    logic t;
    @(posedge aclk);
    {araddr, arvalid, rready} <= {a, 2'b11};
    do begin @(negedge aclk); t = arready; @(posedge aclk); end while (!t);
    arvalid <= 1'b0;
    do begin @(negedge aclk); {t, d, r} = {rvalid, rdata, rresp}; @(posedge aclk); end
      while (!t);
    rready <= 1'b0;
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    rd(a);
    chk(d, e);
  endtask
  // execute one instruction and wait until the core is idle again
  task automatic ex(input logic [15:0] i);
    wr(8'h04, {16'h0, i});
    wr(8'h00, 32'h1);
    do rd(8'h34); while (d[1] !== 1'b0);
  endtask
  task automatic print_verdict;
    $display("errors %0d checks %0d", err_count, samples_checked);
    if (err_count == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // watchdog, far beyond the few hundred cycles the sequence needs
  initial
  begin
    repeat (20000) @(posedge aclk);
    err_count++;
    print_verdict;
  end
  initial
  begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    rc(8'h08, 32'hA000_0000);
    chk(fetch_addr, 32'hA000_0000);
    rc(8'h38, 32'h0);
    chk(r, 2'h2);
    ex(16'hE080); rc(8'h40, 32'hFFFF_FF80);
    ex(16'h8880); rc(8'h10, 32'h7000_0001);
    ex(16'h7001); rc(8'h10, 32'h7000_0001);
    rc(8'h40, 32'hFFFF_FF81);
    // byte load through post-increment wraps the pointer past the top
    wr(8'h48, 32'hFFFF_FFFF);
    wr(8'h24, 32'h80);
    ex(16'h6324); rc(8'h4C, 32'hFFFF_FF80);
    rc(8'h48, 32'h0);
    chk(last_addr, 32'hFFFF_FFFF);
    ex(16'h2236); rc(8'h48, 32'hFFFF_FFFC);
    chk(last_addr, 32'hFFFF_FFFC);
    chk(last_size, 2'h2);
    wr(8'h08, 32'h102);
    ex(16'hD401); rc(8'h28, 32'h108);
    wr(8'h0C, 32'h200);
    ex(16'hC603); rc(8'h28, 32'h20C);
    // branch back by two words: slot first, then the target
    wr(8'h08, 32'h100);
    ex(16'hAFFE); rc(8'h08, 32'h102);
    ex(16'h0009); rc(8'h08, 32'h100);
    ex(16'hAFFE);
    ex(16'hAFFE); rc(8'h08, 32'h102);
    rd(8'h34); chk(d[5], 1'b1);
    wr(8'h1C, 32'h1);
    wr(8'h20, 32'h5A);
    repeat (2) @(posedge aclk);
    chk({xlate_en, sid_valid, space_id}, {2'b11, 8'h5A});
    // index and base registers for the remaining address modes
    wr(8'h40, 32'h10);
    chk(r, 2'h0);
    wr(8'h44, 32'h1000);
    rc(8'h50, 32'h80);
    ex(16'h5213); rc(8'h28, 32'h100C);
    ex(16'h031C); rc(8'h28, 32'h1010);
    ex(16'hCC00); rc(8'h28, 32'h210);
    chk(mem_size, 2'h0);
    // register-relative branch, then untaken delayed and taken plain conditional
    wr(8'h08, 32'h300);
    ex(16'h0123); rc(8'h2C, 32'h1304);
    chk(fetch_addr, 32'h302);
    ex(16'h0009); chk(fetch_addr, 32'h1304);
    ex(16'h8F10); rd(8'h34); chk(d[2], 1'b1);
    ex(16'h0009); chk(fetch_addr, 32'h1308);
    ex(16'h8902); chk(fetch_addr, 32'h1310);
    // return drops privilege; slot fetches with the old mode only
    wr(8'h14, 32'h1);
    wr(8'h18, 32'h2000);
    ex(16'h002B); chk({fetch_priv, data_priv}, 2'b10);
    rc(8'h10, 32'h1);
    ex(16'h0502); rc(8'h54, 32'h1);
    chk({fetch_priv, data_priv}, 2'b00);
    chk(fetch_addr, 32'h2000);
    wr(8'h00, 32'h2); rd(8'h34); chk(d[5], 1'b0);
    wr(8'h38, 32'h1);
    chk(r, 2'h2);
    // pair mode: floating post-increment steps by eight
    wr(8'h04, 32'hF619);
    wr(8'h00, 32'h5);
    do rd(8'h34); while (d[1] !== 1'b0);
    rc(8'h44, 32'h1008);
    chk(last_size, 2'h3);
    print_verdict;
  end
endmodule
